//--- logic/interrupt_priority_level_regs.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
module interrupt_priority_level_regs (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ipl_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [ipl_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [ipl_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [1:0]                    dma_request,
    input  wire logic                          watchdog_request,
    input  wire logic                          refresh_request,
    output ipl_pkg::level_map_t                levels,
    output ipl_pkg::pair_pick_t                dma_pick,
    output ipl_pkg::pair_pick_t                watchdog_pick
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ipl_pkg::NUM_REG-1:0][ipl_pkg::REG_W-1:0] priority_reg;
        logic [ipl_pkg::DATA_W-1:0]                      rdata;
        logic                                            err;
        ipl_pkg::level_map_t                             levels;
        ipl_pkg::pair_pick_t                             dma_pick;
        ipl_pkg::pair_pick_t                             watchdog_pick;
    } state_t;

    localparam state_t STATE_RESET = '{
        priority_reg  : {ipl_pkg::NUM_REG{ipl_pkg::RESET_PRIORITY}},
        rdata         : ipl_pkg::RESET_RDATA,
        err           : 1'b0,
        levels        : '0,
        dma_pick      : '0,
        watchdog_pick : '0
    };

    state_t state;
    state_t next_state;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic decode_hit(input logic [ipl_pkg::ADDR_W-1:0] addr);
        unique case (addr)
            ipl_pkg::OFF_DMA_WATCHDOG,
            ipl_pkg::OFF_ETHER_DMA_TIMER,
            ipl_pkg::OFF_EXTERNAL_LINE,
            ipl_pkg::OFF_TIMER_SERIAL,
            ipl_pkg::OFF_SERIAL_PORT:  decode_hit = 1'b1;
            default:                   decode_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] decode_index(input logic [ipl_pkg::ADDR_W-1:0] addr);
        unique case (addr)
            ipl_pkg::OFF_DMA_WATCHDOG:    decode_index = ipl_pkg::IDX_DMA_WATCHDOG;
            ipl_pkg::OFF_ETHER_DMA_TIMER: decode_index = ipl_pkg::IDX_ETHER_DMA_TIMER;
            ipl_pkg::OFF_EXTERNAL_LINE:   decode_index = ipl_pkg::IDX_EXTERNAL_LINE;
            ipl_pkg::OFF_TIMER_SERIAL:    decode_index = ipl_pkg::IDX_TIMER_SERIAL;
            ipl_pkg::OFF_SERIAL_PORT:     decode_index = ipl_pkg::IDX_SERIAL_PORT;
            default:                      decode_index = ipl_pkg::IDX_DMA_WATCHDOG;
        endcase
    endfunction

    // writable bits per register; reserved positions never take data
    function automatic logic [ipl_pkg::REG_W-1:0] field_mask(input logic [2:0] idx);
        unique case (idx)
            ipl_pkg::IDX_DMA_WATCHDOG:    field_mask = ipl_pkg::MASK_DMA_WATCHDOG;
            ipl_pkg::IDX_ETHER_DMA_TIMER: field_mask = ipl_pkg::MASK_ETHER_DMA_TIMER;
            default:                      field_mask = ipl_pkg::MASK_FULL;
        endcase
    endfunction

    function automatic ipl_pkg::level_t nibble(
        input logic [ipl_pkg::REG_W-1:0] value,
        input int                        lsb
    );
        nibble = value[lsb +: ipl_pkg::LEVEL_W];
    endfunction

    // spread the register contents onto the per-source level lines
    function automatic ipl_pkg::level_map_t map_levels(
        input logic [ipl_pkg::NUM_REG-1:0][ipl_pkg::REG_W-1:0] regs
    );
        logic [ipl_pkg::REG_W-1:0] dw;
        logic [ipl_pkg::REG_W-1:0] et;
        logic [ipl_pkg::REG_W-1:0] ex;
        logic [ipl_pkg::REG_W-1:0] ts;
        logic [ipl_pkg::REG_W-1:0] sp;
        dw = regs[ipl_pkg::IDX_DMA_WATCHDOG];
        et = regs[ipl_pkg::IDX_ETHER_DMA_TIMER];
        ex = regs[ipl_pkg::IDX_EXTERNAL_LINE];
        ts = regs[ipl_pkg::IDX_TIMER_SERIAL];
        sp = regs[ipl_pkg::IDX_SERIAL_PORT];
        map_levels.external_line[0] = nibble(ex, ipl_pkg::FIELD_HI);
        map_levels.external_line[1] = nibble(ex, ipl_pkg::FIELD_MH);
        map_levels.external_line[2] = nibble(ex, ipl_pkg::FIELD_ML);
        map_levels.external_line[3] = nibble(ex, ipl_pkg::FIELD_LO);
        map_levels.pulse_timer[0]   = nibble(ts, ipl_pkg::FIELD_HI);
        map_levels.pulse_timer[1]   = nibble(ts, ipl_pkg::FIELD_MH);
        map_levels.pulse_timer[2]   = nibble(ts, ipl_pkg::FIELD_ML);
        map_levels.fifo_serial_one  = nibble(ts, ipl_pkg::FIELD_LO);
        map_levels.fifo_serial_two  = nibble(sp, ipl_pkg::FIELD_HI);
        map_levels.fifo_sio         = nibble(sp, ipl_pkg::FIELD_MH);
        map_levels.plain_serial[0]  = nibble(sp, ipl_pkg::FIELD_ML);
        map_levels.plain_serial[1]  = nibble(sp, ipl_pkg::FIELD_LO);
        map_levels.dma_channel[0]   = nibble(dw, ipl_pkg::FIELD_MH);
        map_levels.dma_channel[1]   = nibble(dw, ipl_pkg::FIELD_MH);
        map_levels.watchdog         = nibble(dw, ipl_pkg::FIELD_ML);
        map_levels.refresh          = nibble(dw, ipl_pkg::FIELD_ML);
        map_levels.ether_dma        = nibble(et, ipl_pkg::FIELD_HI);
        map_levels.free_timer       = nibble(et, ipl_pkg::FIELD_MH);
    endfunction

    // ------------------------------------------------------------------
    // shared-field tie-breaks
    // ------------------------------------------------------------------
    ipl_pkg::pair_pick_t dma_pick_now;
    ipl_pkg::pair_pick_t watchdog_pick_now;

    shared_pair_select dma_pair (
        .request_first  (dma_request[0]),
        .request_second (dma_request[1]),
        .level          (state.levels.dma_channel[0]),
        .pick           (dma_pick_now)
    );

    shared_pair_select watchdog_pair (
        .request_first  (watchdog_request),
        .request_second (refresh_request),
        .level          (state.levels.watchdog),
        .pick           (watchdog_pick_now)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic                       setup_phase;
    logic                       access_phase;
    logic                       hit;
    logic [2:0]                 index;
    logic [ipl_pkg::REG_W-1:0]  lane_mask;
    logic [ipl_pkg::REG_W-1:0]  write_mask;

    always_comb
    begin
        setup_phase  = psel & ~penable;
        access_phase = psel & penable;
        hit          = decode_hit(paddr);
        index        = decode_index(paddr);
        // only the two low byte lanes hold register bits
        lane_mask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        write_mask   = lane_mask & field_mask(index);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;

        // reads are captured in the setup cycle so prdata comes from a flop
        if (setup_phase)
        begin
            next_state.err   = ~hit;
            next_state.rdata = ipl_pkg::RESET_RDATA;
            if (hit && !pwrite)
            begin
                // reserved bits hold zero, so they read back as zero
                next_state.rdata[ipl_pkg::REG_W-1:0] = state.priority_reg[index];
            end
        end

        // a write lands at the edge that completes the access phase
        if (access_phase && pwrite && hit)
        begin
            next_state.priority_reg[index] =
                (state.priority_reg[index] & ~write_mask) |
                (pwdata[ipl_pkg::REG_W-1:0] & write_mask);
        end

        // levels follow the written value at the same edge
        next_state.levels        = map_levels(next_state.priority_reg);
        next_state.dma_pick      = dma_pick_now;
        next_state.watchdog_pick = watchdog_pick_now;
    end

    // no standby input exists: only presetn clears the registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= STATE_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        pready        = access_phase;
        prdata        = state.rdata;
        pslverr       = access_phase & state.err;
        levels        = state.levels;
        dma_pick      = state.dma_pick;
        watchdog_pick = state.watchdog_pick;
    end

endmodule // interrupt_priority_level_regs

//--- logic/ipl_pkg.sv
package ipl_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int REG_W   = 16;
    localparam int LEVEL_W = 4;
    localparam int NUM_REG = 5;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_DMA_WATCHDOG   = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_ETHER_DMA_TIMER = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_EXTERNAL_LINE  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_TIMER_SERIAL   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_SERIAL_PORT    = 12'h010;

    // register indices in the register array
    localparam logic [2:0] IDX_DMA_WATCHDOG    = 3'h0;
    localparam logic [2:0] IDX_ETHER_DMA_TIMER = 3'h1;
    localparam logic [2:0] IDX_EXTERNAL_LINE   = 3'h2;
    localparam logic [2:0] IDX_TIMER_SERIAL    = 3'h3;
    localparam logic [2:0] IDX_SERIAL_PORT     = 3'h4;

    // ------------------------------------------------------------------
    // field positions (low bit of each 4-bit level field)
    // ------------------------------------------------------------------
    localparam int FIELD_HI  = 12;
    localparam int FIELD_MH  = 8;
    localparam int FIELD_ML  = 4;
    localparam int FIELD_LO  = 0;

    // writable bits of each register; the rest read as zero
    localparam logic [REG_W-1:0] MASK_DMA_WATCHDOG    = 16'h0FF0;
    localparam logic [REG_W-1:0] MASK_ETHER_DMA_TIMER = 16'hFF00;
    localparam logic [REG_W-1:0] MASK_FULL            = 16'hFFFF;

    // ------------------------------------------------------------------
    // reset values and level limits
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0]  RESET_PRIORITY = 16'h0000;
    localparam logic [DATA_W-1:0] RESET_RDATA    = 32'h0000_0000;
    localparam logic [LEVEL_W-1:0] LEVEL_LOWEST  = 4'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_HIGHEST = 4'hF;

    typedef logic [LEVEL_W-1:0] level_t;

    // levels presented to the priority-resolution logic
    typedef struct packed {
        level_t [3:0] external_line;   // index n = request line n
        level_t [2:0] pulse_timer;     // index n = pulse timer unit n
        level_t       fifo_serial_one;
        level_t       fifo_serial_two;
        level_t       fifo_sio;
        level_t [1:0] plain_serial;    // index 0 = serial i/o 1, 1 = serial i/o 2
        level_t [1:0] dma_channel;     // both channels carry one shared level
        level_t       watchdog;
        level_t       refresh;         // same level as the watchdog
        level_t       ether_dma;
        level_t       free_timer;
    } level_map_t;

    // outcome of a tie-break between two sources sharing one level
    typedef struct packed {
        logic   valid;
        logic   second;   // 0: first source chosen, 1: second source chosen
        level_t level;
    } pair_pick_t;

endpackage : ipl_pkg

//--- logic/shared_pair_select.sv
// two sources share one level field; the first source wins a tie
module shared_pair_select (
    input  wire logic          request_first,
    input  wire logic          request_second,
    input  wire ipl_pkg::level_t level,
    output ipl_pkg::pair_pick_t pick
);

    always_comb
    begin
        pick.valid  = request_first | request_second;
        pick.second = request_second & ~request_first;
        pick.level  = level;
    end

endmodule // shared_pair_select

//--- tb/far_side_model.sv
// ------------------------------------------------------------------
// request sources seen by the resolution logic
// ------------------------------------------------------------------
module far_side_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] req_cmd,
    output logic      [1:0] dma_request,
    output logic            watchdog_request,
    output logic            refresh_request
);
    timeunit 1ns;
    timeprecision 1ps;
    // sources raise requests off a clock edge, so ties arrive in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {refresh_request, watchdog_request, dma_request} <= 4'h0;
        end
        else
        begin
            {refresh_request, watchdog_request, dma_request} <= req_cmd;
        end
    end
endmodule // far_side_model

//--- tb/ipl_asserts.sv
// ------------------------------------------------------------------
// port-level checks of the priority level registers
// ------------------------------------------------------------------
module ipl_asserts (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ipl_pkg::ADDR_W-1:0]  paddr,
    input wire logic [ipl_pkg::DATA_W-1:0]  pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [ipl_pkg::DATA_W-1:0]  prdata,
    input wire logic [1:0]                  dma_request,
    input wire logic                        watchdog_request,
    input wire logic                        refresh_request,
    input wire ipl_pkg::level_map_t         levels,
    input wire ipl_pkg::pair_pick_t         dma_pick,
    input wire ipl_pkg::pair_pick_t         watchdog_pick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence ext_write;
        psel && penable && pwrite && paddr == ipl_pkg::OFF_EXTERNAL_LINE && pstrb[1:0] == 2'b11;
    endsequence
    sequence first_reg_read;
        psel && penable && !pwrite && paddr == ipl_pkg::OFF_DMA_WATCHDOG;
    endsequence
    a_ext_write_level: assert property (ext_write |=>
        levels.external_line[0] == $past(pwdata[15:12])
        && levels.external_line[3] == $past(pwdata[3:0]))
        else $error("external line level not taken from the write");
    a_reserved_read_zero: assert property (first_reg_read |->
        prdata[15:12] == 4'h0 && prdata[3:0] == 4'h0)
        else $error("reserved bits of first register read nonzero");
    a_dma_shared: assert property (levels.dma_channel[0] == levels.dma_channel[1])
        else $error("dma channels carry different levels");
    a_watchdog_shared: assert property (levels.watchdog == levels.refresh)
        else $error("watchdog and refresh carry different levels");
    a_reset_clears: assert property ($rose(presetn) |-> levels == '0)
        else $error("levels not cleared by reset");
    a_dma_tie_break: assert property (dma_request == 2'b11 |=> dma_pick.valid && !dma_pick.second)
        else $error("dma channel 0 lost a tie");
    a_watchdog_tie_break: assert property (watchdog_request && refresh_request |=>
        watchdog_pick.valid && !watchdog_pick.second)
        else $error("watchdog lost a tie to refresh");
    a_second_alone: assert property (dma_request == 2'b10 |=> dma_pick.valid && dma_pick.second)
        else $error("lone dma channel 1 not picked");
    a_pick_level: assert property (dma_request != 2'b00 |=>
        dma_pick.level == $past(levels.dma_channel[0]))
        else $error("dma pick carries a wrong level");
endmodule // ipl_asserts

bind interrupt_priority_level_regs ipl_asserts ipl_asserts_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .dma_request, .watchdog_request, .refresh_request, .levels, .dma_pick, .watchdog_pick
);

//--- tb/testbench.sv
// ------------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_request, refresh_request;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, req_cmd;
    logic [1:0]  dma_request;
    ipl_pkg::level_map_t levels, exp_lv;
    ipl_pkg::pair_pick_t dma_pick, watchdog_pick;
    int failures;
    int comparisons;
    logic [11:0] offs [5] = '{ipl_pkg::OFF_DMA_WATCHDOG, ipl_pkg::OFF_ETHER_DMA_TIMER,
        ipl_pkg::OFF_EXTERNAL_LINE, ipl_pkg::OFF_TIMER_SERIAL, ipl_pkg::OFF_SERIAL_PORT};
    logic [15:0] wvals [5] = '{16'hF96F, 16'h87FF, 16'hF05A, 16'h1E2D, 16'hC3B4};
    logic [15:0] rvals [5] = '{16'h0960, 16'h8700, 16'hF05A, 16'h1E2D, 16'hC3B4};

    interrupt_priority_level_regs interrupt_priority_level_regs_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .dma_request,
        .watchdog_request, .refresh_request, .levels, .dma_pick, .watchdog_pick);
    far_side_model far_side_model_i (.pclk, .presetn, .req_cmd, .dma_request,
        .watchdog_request, .refresh_request);

    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // request held until pready is seen high; release is left to the caller
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
    endtask
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset_values();
        logic [31:0] r;
        logic        e;
        foreach (offs[i])
        begin
            apb(1'b0, offs[i], 32'h0000_0000, r, e);
            chk(96'(r), 96'h0);
        end
        idle();
        chk(96'(levels), 96'h0);
    endtask
    task automatic t_fields();
        logic [31:0] r;
        logic        e;
        foreach (offs[i])
            apb(1'b1, offs[i], {16'hFFFF, wvals[i]}, r, e);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF, r, e);
        chk(96'(e), 96'h1);
        foreach (offs[i])
        begin
            apb(1'b0, offs[i], 32'h0000_0000, r, e);
            chk(96'(r), 96'({16'h0000, rvals[i]}));
        end
        idle();
        exp_lv.external_line   = {4'hA, 4'h5, 4'h0, 4'hF};
        exp_lv.pulse_timer     = {4'h2, 4'hE, 4'h1};
        exp_lv.fifo_serial_one = 4'hD;
        exp_lv.fifo_serial_two = 4'hC;
        exp_lv.fifo_sio        = 4'h3;
        exp_lv.plain_serial    = {4'h4, 4'hB};
        exp_lv.dma_channel     = {4'h9, 4'h9};
        exp_lv.watchdog        = 4'h6;
        exp_lv.refresh         = 4'h6;
        exp_lv.ether_dma       = 4'h8;
        exp_lv.free_timer      = 4'h7;
        chk(96'(levels), 96'(exp_lv));
    endtask
    // one cycle through the source model, one through the block
    task automatic t_picks(input logic [3:0] cmd, input logic v, input logic second);
        req_cmd <= cmd;
        repeat (3) @(posedge pclk);
        chk(96'(dma_pick), 96'({v, second, 4'h9}));
        chk(96'(watchdog_pick), 96'({v, second, 4'h6}));
    endtask
    // a write with only the low byte lane enabled leaves the high byte alone
    task automatic t_strobes();
        logic [31:0] r;
        logic        e;
        pstrb <= 4'h1;
        apb(1'b1, ipl_pkg::OFF_SERIAL_PORT, 32'h0000_0000, r, e);
        pstrb <= 4'hF;
        apb(1'b0, ipl_pkg::OFF_SERIAL_PORT, 32'h0000_0000, r, e);
        chk(96'(r), 96'h0000_C300);
        idle();
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #100us;
        failures++;
        summarize();
    end
    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'hF;
        req_cmd = 4'h0;
        do_reset();
        t_reset_values();
        t_fields();
        t_picks(4'b1111, 1'b1, 1'b0);
        t_picks(4'b1010, 1'b1, 1'b1);
        t_picks(4'b0101, 1'b1, 1'b0);
        t_picks(4'b0000, 1'b0, 1'b0);
        t_strobes();
        do_reset();
        t_reset_values();
        summarize();
    end
endmodule // testbench
